// [src/bpp_port_pins.sv]
/*
  Port pin logic for three small general-purpose ports: output latches,
  direction registers and pull-up selects, reached by the CPU with byte and
  single-bit accesses.
  Assumes the CPU issues at most one access per cycle and that pin inputs are
  asynchronous to core_clk_i.
*/
// Functional notes
// R1: An output-mode pin is driven with the value held in its output latch.
// R2: Reading a port returns the pin level for input bits and the latch for output bits.
// R3: Reset clears every output latch to zero.
// R4: The shared input-only bit of port three is read-only and follows its pin.
// R5: Writing an input-mode bit updates its latch while the pin stays undriven.
// R6: Each latch holds its last written value until a new write or a reset.
// R7: Reading a port never changes any output latch.
// R8: A bit operation on an output bit works on the latch and drives the result.
// R9: A bit operation on an input bit works on the pin level and stores the result.
// R10: A bit operation touches the whole byte, so untargeted input latches take pin values.
// R11: Data and pull-up registers accept both byte and single-bit writes.
// R12: A data bit of 0 means low and 1 means high, for output and for input.
// R13: A set pull-up select bit connects the on-chip pull-up to its pin.
// R14: Reset clears every pull-up select, disconnecting all pull-ups.
// R15: Direction 0 is output with buffer on, 1 is input; reset sets all directions to input.
// R16: A selected pull-up is only applied while its pin is an input.
// R17: Bits without a pin ignore writes and read as zero, except in the direction registers, where they read as one.
module bpp_port_pins
  import bpp_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  // CPU data access.
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic        cpu_bit_op_i,
  input  wire logic [2:0]  cpu_bit_sel_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic      [7:0]  cpu_rdata_o,
  output logic             cpu_rvalid_o,
  // Port two pins.
  input  wire logic [7:0]  port_two_pin_i,
  output logic      [7:0]  port_two_out_o,
  output logic      [7:0]  port_two_oe_o,
  output logic      [7:0]  port_two_pullup_o,
  // Port three pins, bit four is the reset_shared_input_pin.
  input  wire logic [7:0]  port_three_pin_i,
  output logic      [7:0]  port_three_out_o,
  output logic      [7:0]  port_three_oe_o,
  output logic      [7:0]  port_three_pullup_o,
  // Port four pins.
  input  wire logic [7:0]  port_four_pin_i,
  output logic      [7:0]  port_four_out_o,
  output logic      [7:0]  port_four_oe_o,
  output logic      [7:0]  port_four_pullup_o
);

  // Per-port constant tables.
  localparam logic [7:0] IO_MASK [NUM_PORTS] = '{IO_MASK_PORT_TWO, IO_MASK_PORT_THREE,
                                                  IO_MASK_PORT_FOUR};
  localparam logic [7:0] PU_MASK [NUM_PORTS] = '{IO_MASK_PORT_TWO,
                                                  IO_MASK_PORT_THREE | SHARED_INPUT_MASK,
                                                  IO_MASK_PORT_FOUR};
  localparam logic [7:0] RD_ONLY [NUM_PORTS] = '{8'h00, SHARED_INPUT_MASK, 8'h00};
  localparam logic [15:0] A_LATCH [NUM_PORTS] = '{ADDR_PORT_TWO_LATCH, ADDR_PORT_THREE_LATCH,
                                                   ADDR_PORT_FOUR_LATCH};
  localparam logic [15:0] A_DIR [NUM_PORTS] = '{ADDR_PORT_TWO_DIR, ADDR_PORT_THREE_DIR,
                                                 ADDR_PORT_FOUR_DIR};
  localparam logic [15:0] A_PU [NUM_PORTS] = '{ADDR_PORT_TWO_PULLUP, ADDR_PORT_THREE_PULLUP,
                                                ADDR_PORT_FOUR_PULLUP};

  // Register state and synchronised pins.
  logic [7:0] latch_ff    [NUM_PORTS];
  logic [7:0] dir_ff      [NUM_PORTS];
  logic [7:0] pu_ff       [NUM_PORTS];
  logic [7:0] oe_ff       [NUM_PORTS];
  logic [7:0] pull_ff     [NUM_PORTS];
  logic [7:0] pin_meta_ff [NUM_PORTS];
  logic [7:0] pin_sync_ff [NUM_PORTS];
  logic [7:0] rdata_ff;
  logic       rvalid_ff;

  // Decoded values.
  logic [7:0] pin_raw   [NUM_PORTS];
  logic [7:0] port_rd   [NUM_PORTS];
  logic [7:0] nxt_latch [NUM_PORTS];
  logic [7:0] nxt_dir   [NUM_PORTS];
  logic [7:0] nxt_pu    [NUM_PORTS];
  logic [NUM_PORTS-1:0] hit_latch;
  logic [NUM_PORTS-1:0] hit_dir;
  logic [NUM_PORTS-1:0] hit_pu;
  logic [7:0] bit_mask;
  logic [7:0] nxt_rdata;

  assign pin_raw[0] = port_two_pin_i;
  assign pin_raw[1] = port_three_pin_i;
  assign pin_raw[2] = port_four_pin_i;

  // A single-bit access only replaces the selected bit of the byte it rewrites.
  assign bit_mask = cpu_bit_op_i ? (8'h01 << cpu_bit_sel_i) : 8'hFF;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic [7:0] dir_in;
      logic [7:0] merged_latch;
      logic [7:0] merged_dir;
      logic [7:0] merged_pu;

      // Register decode.
      assign hit_latch[gp] = (cpu_addr_i == A_LATCH[gp]);
      assign hit_dir[gp]   = (cpu_addr_i == A_DIR[gp]);
      assign hit_pu[gp]    = (cpu_addr_i == A_PU[gp]);

      // Read view: pin level on input bits, latch on output bits.
      assign dir_in      = dir_ff[gp] | RD_ONLY[gp];
      assign port_rd[gp] = ((dir_in & pin_sync_ff[gp]) | (~dir_in & latch_ff[gp]))
                           & (IO_MASK[gp] | RD_ONLY[gp]); // R2 R4 R12 R17

      // Bit operations merge into the read view, so the operand is the latch on
      // output bits and the pin on input bits, and every other input latch in
      // the byte is rewritten with its pin level.
      assign merged_latch = (port_rd[gp] & ~bit_mask) | (cpu_wdata_i & bit_mask); // R8 R9 R10
      assign merged_dir   = (dir_ff[gp] & ~bit_mask) | (cpu_wdata_i & bit_mask);
      assign merged_pu    = (pu_ff[gp] & ~bit_mask) | (cpu_wdata_i & bit_mask);

      // Only pinned bits take written values; the shared input bit has no latch.
      assign nxt_latch[gp] = (cpu_wr_i && hit_latch[gp])
                             ? (merged_latch & IO_MASK[gp]) : latch_ff[gp]; // R4 R5 R6 R11 R17
      assign nxt_dir[gp]   = (cpu_wr_i && hit_dir[gp])
                             ? ((merged_dir & IO_MASK[gp]) | ~IO_MASK[gp]) : dir_ff[gp];
      assign nxt_pu[gp]    = (cpu_wr_i && hit_pu[gp])
                             ? (merged_pu & PU_MASK[gp]) : pu_ff[gp]; // R11 R17

      // Pin synchroniser; only the second stage is read.
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_meta_ff[gp] <= 8'h00;
          pin_sync_ff[gp] <= 8'h00;
        end else begin
          pin_meta_ff[gp] <= pin_raw[gp];
          pin_sync_ff[gp] <= pin_meta_ff[gp];
        end
      end

      // Port registers plus the registered pin controls derived from them.
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          latch_ff[gp] <= LATCH_RESET;   // R3
          dir_ff[gp]   <= DIR_RESET;     // R15
          pu_ff[gp]    <= PULLUP_RESET;  // R14
          oe_ff[gp]    <= 8'h00;
          pull_ff[gp]  <= 8'h00;
        end else begin
          latch_ff[gp] <= nxt_latch[gp];
          dir_ff[gp]   <= nxt_dir[gp];
          pu_ff[gp]    <= nxt_pu[gp];
          oe_ff[gp]    <= ~nxt_dir[gp] & IO_MASK[gp];             // R1 R5 R15
          pull_ff[gp]  <= nxt_pu[gp] & (nxt_dir[gp] | RD_ONLY[gp]); // R13 R16
        end
      end
    end
  endgenerate

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (hit_latch[i]) nxt_rdata = port_rd[i];
      if (hit_dir[i])   nxt_rdata = dir_ff[i];
      if (hit_pu[i])    nxt_rdata = pu_ff[i];
    end
  end

  // Read answer is registered; a read has no side effect on any latch.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= cpu_rd_i;
      if (cpu_rd_i) rdata_ff <= nxt_rdata; // R7
    end
  end

  // Outputs straight from flip-flops.
  assign cpu_rdata_o         = rdata_ff;
  assign cpu_rvalid_o        = rvalid_ff;
  assign port_two_out_o      = latch_ff[0]; // R1 R12
  assign port_two_oe_o       = oe_ff[0];
  assign port_two_pullup_o   = pull_ff[0];
  assign port_three_out_o    = latch_ff[1];
  assign port_three_oe_o     = oe_ff[1];
  assign port_three_pullup_o = pull_ff[1];
  assign port_four_out_o     = latch_ff[2];
  assign port_four_oe_o      = oe_ff[2];
  assign port_four_pullup_o  = pull_ff[2];

  // Checks on the port behaviour.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_byte_wr_p2;
    cpu_wr_i && !cpu_bit_op_i && cpu_addr_i == ADDR_PORT_TWO_LATCH;
  endsequence

  a_oe_from_dir: assert property (port_two_oe_o == (~dir_ff[0] & IO_MASK_PORT_TWO)) // R15
    else $error("port two enable does not match direction");
  a_out_is_latch: assert property (port_three_out_o == latch_ff[1]) // R1
    else $error("port three output differs from its latch");
  a_byte_write: assert property (s_byte_wr_p2 |=> latch_ff[0] == ($past(cpu_wdata_i) & 8'h0F)) // R11
    else $error("byte write to port two latch lost");
  a_latch_holds: assert property (!(cpu_wr_i && hit_latch[2]) |=> $stable(latch_ff[2])) // R6
    else $error("port four latch changed without a write");
  a_read_no_effect: assert property (cpu_rd_i && !cpu_wr_i |=> $stable(latch_ff[0])) // R7
    else $error("read altered a latch");
  a_shared_bit_ro: assert property (latch_ff[1][SHARED_INPUT_BIT] == 1'b0) // R4
    else $error("shared input bit gained a latch");
  a_unused_zero: assert property (cpu_rd_i && hit_latch[0] |=> cpu_rdata_o[7:4] == 4'h0) // R17
    else $error("unpinned port two bits read nonzero");
  a_pull_input_only: assert property (
      (port_four_pullup_o & ~dir_ff[2]) == 8'h00) // R16
    else $error("pull-up applied on an output pin");
  a_read_view: assert property (cpu_rd_i && hit_latch[0] ##1 rvalid_ff |->
      cpu_rdata_o == $past(port_rd[0])) // R2
    else $error("port two read returned wrong view");
  a_bit_op_input: assert property (cpu_wr_i && cpu_bit_op_i && hit_latch[0]
      && dir_ff[0][1] && cpu_bit_sel_i != 3'h1 |=>
      latch_ff[0][1] == $past(pin_sync_ff[0][1])) // R10
    else $error("untargeted input latch did not take the pin level");

  // Helper terms for the checks below; they are plain decodes, not state.
  logic       any_hit;
  logic [7:0] wr_bits;
  assign any_hit = |{hit_latch, hit_dir, hit_pu};
  assign wr_bits = cpu_wdata_i & bit_mask;

  // A whole-byte write to the port four direction register.
  sequence s_byte_wr_dir4;
    cpu_wr_i && !cpu_bit_op_i && hit_dir[2];
  endsequence

  // A whole-byte write to the port three pull-up select register.
  sequence s_byte_wr_pu3;
    cpu_wr_i && !cpu_bit_op_i && hit_pu[1];
  endsequence

  // A single-bit write to the port two latch on one of its pinned bits.
  sequence s_bit_wr_p2;
    cpu_wr_i && cpu_bit_op_i && hit_latch[0] && cpu_bit_sel_i < 3'h4;
  endsequence

  // A read of an address that no register of this block answers.
  sequence s_stray_rd;
    cpu_rd_i && !any_hit;
  endsequence

  // Register write checks; unpinned direction bits must stay at input.
  a_dir_write: assert property (s_byte_wr_dir4 |=> // R15
      dir_ff[2] == (($past(cpu_wdata_i) & IO_MASK_PORT_FOUR) | ~IO_MASK_PORT_FOUR))
    else $error("port four direction write lost");

  a_pu_write: assert property (s_byte_wr_pu3 |=> // R11
      pu_ff[1] == ($past(cpu_wdata_i) & (IO_MASK_PORT_THREE | SHARED_INPUT_MASK)))
    else $error("port three pull-up write lost");

  // The selected bit must carry the written value, whatever the merge did elsewhere.
  a_bit_target: assert property (s_bit_wr_p2 |=> // R11
      (latch_ff[0] & $past(bit_mask)) == $past(wr_bits))
    else $error("single-bit write missed its target bit");

  // Stray accesses must neither answer with data nor disturb a latch.
  a_stray_read: assert property (s_stray_rd |=> cpu_rdata_o == 8'h00) // R17
    else $error("unmapped address read nonzero");

  a_stray_write: assert property (cpu_wr_i && !any_hit |=> $stable(latch_ff[1])) // R17
    else $error("unmapped write changed a latch");

  // The read answer is a single registered pulse per strobe.
  a_rvalid_pulse: assert property (cpu_rd_i |=> cpu_rvalid_o) // R2
    else $error("read strobe gave no answer");

  a_no_rvalid: assert property (!cpu_rd_i |=> !cpu_rvalid_o) // R2
    else $error("answer without a read strobe");

  // Pin controls must always agree with the registers behind them.
  a_out_unpinned: assert property ((port_two_out_o & ~IO_MASK_PORT_TWO) == 8'h00) // R17
    else $error("unpinned port two output bit set");

  a_oe_three: assert property (port_three_oe_o == (~dir_ff[1] & IO_MASK_PORT_THREE)) // R1 R15
    else $error("port three enable does not match direction");

  a_pull_two: assert property (port_two_pullup_o == (pu_ff[0] & dir_ff[0])) // R13 R16
    else $error("port two pull-up does not match its select");

endmodule : bpp_port_pins

// [src/bpp_pkg.sv]
/*
  Constants for the bit-granular port block: register addresses, pin masks
  and reset values for the three small ports.
  Assumes a 16-bit CPU data address space with byte-wide registers.
*/
package bpp_pkg;

  // Register addresses in the CPU data space.
  localparam logic [15:0] ADDR_PORT_TWO_LATCH     = 16'hFF02;
  localparam logic [15:0] ADDR_PORT_THREE_LATCH   = 16'hFF03;
  localparam logic [15:0] ADDR_PORT_FOUR_LATCH    = 16'hFF04;
  localparam logic [15:0] ADDR_PORT_TWO_DIR       = 16'hFF22;
  localparam logic [15:0] ADDR_PORT_THREE_DIR     = 16'hFF23;
  localparam logic [15:0] ADDR_PORT_FOUR_DIR      = 16'hFF24;
  localparam logic [15:0] ADDR_PORT_TWO_PULLUP    = 16'hFF32;
  localparam logic [15:0] ADDR_PORT_THREE_PULLUP  = 16'hFF33;
  localparam logic [15:0] ADDR_PORT_FOUR_PULLUP   = 16'hFF34;

  // Bits that carry a bidirectional pin, per port.
  localparam logic [7:0] IO_MASK_PORT_TWO   = 8'h0F;
  localparam logic [7:0] IO_MASK_PORT_THREE = 8'h04;
  localparam logic [7:0] IO_MASK_PORT_FOUR  = 8'h09;

  // Position of the input-only pin shared with the reset function.
  localparam int unsigned SHARED_INPUT_BIT = 4;
  localparam logic [7:0]  SHARED_INPUT_MASK = 8'h10;

  // Reset values.
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET    = 8'hFF;

  // Number of ports handled by the block.
  localparam int unsigned NUM_PORTS = 3;

endpackage : bpp_pkg

// [verif/bpp_pin_world.sv]
/*
  Model of the external parties on one 8-bit port: drivers, pull-ups and
  floating lines. Assumes the bench enables its own driver only on bits that
  the device leaves undriven.
*/
module bpp_pin_world (
  // Device side.
  input  wire logic       clk_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  // External driver.
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h5A;
  // A floating line toggles, so a stale level is never mistaken for a drive.
  always @(posedge clk_i) float_q <= ~float_q;
  // Device buffer first, then the outside driver, then the pull-up.
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
      | (~oe_i & ~ext_en_i & (pullup_i | float_q));
endmodule : bpp_pin_world

// [verif/tb.sv]
/*
  Self-checking bench for the port pin block: register table rows, then
  input-mode, bit-operation, read-only and reset cases.
  Assumes one pin model per port and a 40 MHz core clock.
*/
module tb;
  import bpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd, bop, rvalid;
  logic [2:0]  bsel;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [7:0]  pin [3], out [3], oe [3], pu [3], een [3], eval [3];
  int          miscompares = 0, tests_run = 0;
  // Address, write data, expected read back.
  localparam logic [31:0] ROWS [10] = '{
    {ADDR_PORT_TWO_DIR, 8'h00, 8'hF0}, {ADDR_PORT_THREE_DIR, 8'h00, 8'hFB},
    {ADDR_PORT_FOUR_DIR, 8'h00, 8'hF6}, {ADDR_PORT_TWO_LATCH, 8'hA5, 8'h05},
    {ADDR_PORT_THREE_LATCH, 8'hFF, 8'h04}, {ADDR_PORT_FOUR_LATCH, 8'hFF, 8'h09},
    {ADDR_PORT_TWO_PULLUP, 8'hFF, 8'h0F}, {ADDR_PORT_THREE_PULLUP, 8'hFF, 8'h14},
    {ADDR_PORT_FOUR_PULLUP, 8'hFF, 8'h09}, {16'hFF10, 8'hFF, 8'h00}};

  bpp_port_pins u_bpp_port_pins (.core_clk_i(clk), .resetn_i(rst_n), .cpu_addr_i(addr),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_bit_op_i(bop), .cpu_bit_sel_i(bsel),
    .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid),
    .port_two_pin_i(pin[0]), .port_two_out_o(out[0]), .port_two_oe_o(oe[0]),
    .port_two_pullup_o(pu[0]), .port_three_pin_i(pin[1]), .port_three_out_o(out[1]),
    .port_three_oe_o(oe[1]), .port_three_pullup_o(pu[1]), .port_four_pin_i(pin[2]),
    .port_four_out_o(out[2]), .port_four_oe_o(oe[2]), .port_four_pullup_o(pu[2]));

  // One outside world per port.
  for (genvar k = 0; k < 3; k++) begin : g_world
    bpp_pin_world u_bpp_pin_world (.clk_i(clk), .out_i(out[k]), .oe_i(oe[k]),
      .pullup_i(pu[k]), .ext_en_i(een[k]), .ext_val_i(eval[k]), .pin_o(pin[k]));
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One access; strobes rise after a falling edge and drop one cycle later.
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(negedge clk);
    {wr, rd, addr, wdata, bop, bsel} = {w, ~w, a, d, b, s};
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask : acc

  // The answer stands for one cycle, so it is looked at right away.
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp({7'h00, rvalid}, 8'h01);
    cmp(rdata, e);
  endtask : rdchk

  // Pin inputs pass a two-stage synchroniser before they can be read.
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog well beyond the hundred or so cycles the sequence needs.
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    {rst_n, wr, rd, bop, bsel, addr, wdata} = '0;
    een = '{8'h00, 8'h10, 8'h00};
    eval = '{8'h00, 8'h00, 8'h00};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    cmp(out[0] | oe[1] | pu[2], 8'h00);
    rdchk(ADDR_PORT_THREE_LATCH, 8'h00);
    rdchk(ADDR_PORT_FOUR_PULLUP, 8'h00);
    rdchk(ADDR_PORT_TWO_DIR, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, ROWS[i][31:16], ROWS[i][15:8]);
      rdchk(ROWS[i][31:16], ROWS[i][7:0]);
    end
    cmp(pin[0] & IO_MASK_PORT_TWO, 8'h05);
    cmp(pu[0] | pu[1], 8'h10);
    cmp(out[1] | oe[1], 8'h04);
    cmp(pu[2], 8'h00);
    acc(1'b1, ADDR_PORT_TWO_DIR, 8'hFF);
    settle();
    cmp(oe[0] | pu[0], 8'h0F);
    rdchk(ADDR_PORT_TWO_LATCH, 8'h0F);
    {een[0], eval[0]} = {8'h0F, 8'h0A};
    settle();
    acc(1'b1, ADDR_PORT_TWO_LATCH, 8'h03);
    rdchk(ADDR_PORT_TWO_LATCH, 8'h0A);
    cmp(pin[0] & IO_MASK_PORT_TWO, 8'h0A);
    een[0] = 8'h00;
    acc(1'b1, ADDR_PORT_TWO_DIR, 8'h00);
    rdchk(ADDR_PORT_TWO_LATCH, 8'h03);
    acc(1'b1, ADDR_PORT_TWO_LATCH, 8'h04, 1'b1, 3'h2);
    rdchk(ADDR_PORT_TWO_LATCH, 8'h07);
    cmp(pin[0] & IO_MASK_PORT_TWO, 8'h07);
    acc(1'b1, ADDR_PORT_TWO_DIR, 8'h02);
    settle();
    acc(1'b1, ADDR_PORT_TWO_LATCH, 8'h00, 1'b1, 3'h0);
    rdchk(ADDR_PORT_TWO_LATCH, 8'h06);
    cmp(pin[0] & IO_MASK_PORT_TWO, 8'h06);
    {een[2], eval[2]} = {8'h09, 8'h01};
    acc(1'b1, ADDR_PORT_FOUR_DIR, 8'hFF);
    settle();
    cmp(pu[2], 8'h09);
    acc(1'b1, ADDR_PORT_FOUR_LATCH, 8'h00, 1'b1, 3'h0);
    cmp(out[2] | oe[2], 8'h00);
    eval[1] = 8'h10;
    settle();
    acc(1'b1, ADDR_PORT_THREE_LATCH, 8'h00, 1'b1, 3'h4);
    rdchk(ADDR_PORT_THREE_LATCH, 8'h14);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    cmp(out[0] | oe[0] | pu[1], 8'h00);
    rst_n = 1'b1;
    rdchk(ADDR_PORT_THREE_PULLUP, 8'h00);
    complete_run();
  end
endmodule : tb
